/* File: gpio_pin_mux_pkg.sv */
// Package with the register map, field layout, carrier types and state types of the pin multiplexer.
package gpio_pin_mux_pkg;

  // Port geometry: six ports of sixteen pins; the first four carry input filtering.
  localparam int NUM_PORTS = 6;
  localparam int NUM_FILT_PORTS = 4;
  localparam int PORT_WIDTH = 16;
  localparam int WINDOW_LEN = 6;

  // Register indices; printed offsets are word indices, the APB byte address is four times these.
  // Port order in every table is A, B, D, E, F, G.
  localparam logic [5:0][15:0] FUNC_IDX = {16'h70D8, 16'h70D4, 16'h70D0, 16'h70CC, 16'h70C4,
                                           16'h70C0};
  localparam logic [5:0][15:0] DIR_IDX = {16'h70D9, 16'h70D5, 16'h70D1, 16'h70CD, 16'h70C5,
                                          16'h70C1};
  localparam logic [3:0][15:0] FILT_IDX = {16'h70D2, 16'h70CE, 16'h70C6, 16'h70C2};
  localparam logic [5:0][15:0] VALUE_IDX = {16'h70F8, 16'h70F4, 16'h70F0, 16'h70EC, 16'h70E4,
                                            16'h70E0};
  localparam logic [5:0][15:0] HIGH_IDX = {16'h70F9, 16'h70F5, 16'h70F1, 16'h70ED, 16'h70E5,
                                           16'h70E1};
  localparam logic [5:0][15:0] LOW_IDX = {16'h70FA, 16'h70F6, 16'h70F2, 16'h70EE, 16'h70E6,
                                          16'h70E2};
  localparam logic [5:0][15:0] INV_IDX = {16'h70FB, 16'h70F7, 16'h70F3, 16'h70EF, 16'h70E7,
                                          16'h70E3};

  // Pins of the filtered ports that actually pass through the six-sample qualifier.
  localparam logic [3:0][15:0] FILT_PIN_MASK = {16'h0007, 16'h0063, 16'hFFFF, 16'hFFFF};

  // Field of the filter register that holds the sampling period in system clocks.
  localparam int FILT_PERIOD_LSB = 0;
  localparam int FILT_PERIOD_W = 8;

  // Port D positions of the protect inputs and the trip inputs of the two PWM groups.
  localparam int PORT_D = 2;
  localparam int PROTECT_A_BIT = 0;
  localparam int PROTECT_B_BIT = 5;
  localparam int TRIP_A_BIT = 1;
  localparam int TRIP_B_BIT = 6;

  // Values after reset: all pins are digital inputs with no drive.
  localparam logic [15:0] FUNC_RESET = 16'h0000;
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [15:0] FILT_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Kinds of register that an address can decode to.
  typedef enum logic [2:0] {
    KIND_NONE  = 3'h0,
    KIND_FUNC  = 3'h1,
    KIND_DIR   = 3'h2,
    KIND_FILT  = 3'h3,
    KIND_VALUE = 3'h4,
    KIND_HIGH  = 3'h5,
    KIND_LOW   = 3'h6,
    KIND_INV   = 3'h7
  } reg_kind_t;

  // Bus slave states, Gray coded along idle to answer.
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;

  // Result of an address decode.
  typedef struct packed {
    reg_kind_t kind;
    logic [2:0] port;
  } reg_decode_t;

  // APB request and answer bundles.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_t;

  // Drive of a set of pins: level and active-low output enable.
  typedef struct packed {
    logic [5:0][15:0] level;
    logic [5:0][15:0] oe_n;
  } pin_drive_t;

  typedef logic [5:0][15:0] port_levels_t;

  // Whole state of the multiplexer.
  typedef struct packed {
    bus_state_t bus;
    apb_resp_t resp;
    logic [5:0][15:0] func;
    logic [5:0][15:0] dir;
    logic [5:0][15:0] value;
    logic [3:0][15:0] filt;
    logic [3:0][7:0] div;
    logic [3:0][15:0][5:0] hist;
    logic [3:0][15:0] qlev;
    pin_drive_t pins;
    port_levels_t periph_in;
    logic [1:0] pwm_hiz;
  } mux_state_t;

endpackage : gpio_pin_mux_pkg

/* File: gpio_pin_mux_port.sv */
// Shared-pin multiplexer and digital I/O ports A, B, D, E, F and G with an APB register slave.
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_mux_port (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // APB register slave.
  input wire gpio_pin_mux_pkg::apb_req_t apb_req,
  output gpio_pin_mux_pkg::apb_resp_t apb_resp,
  // System write-protection unlock level.
  input wire logic write_protect_unlock,
  // Package pins.
  input wire gpio_pin_mux_pkg::port_levels_t pin_level_in,
  output gpio_pin_mux_pkg::pin_drive_t pin_drive,
  // On-chip peripherals that share the pins.
  input wire gpio_pin_mux_pkg::pin_drive_t periph_drive,
  output gpio_pin_mux_pkg::port_levels_t periph_level,
  // PWM protection: bit 0 of each group's extended control, and the high-impedance requests.
  input wire logic [1:0] extended_control_trip_en,
  output logic [1:0] pwm_force_hiz
);

  // Map an aligned word index to a register kind and port; anything else is reserved.
  function automatic gpio_pin_mux_pkg::reg_decode_t decode_index(input logic [15:0] idx);
    gpio_pin_mux_pkg::reg_decode_t d;
    d.kind = gpio_pin_mux_pkg::KIND_NONE;
    d.port = 3'h0;
    for (int k = 0; k < gpio_pin_mux_pkg::NUM_PORTS; k++) begin
      if (idx == gpio_pin_mux_pkg::FUNC_IDX[k]) begin
        d.kind = gpio_pin_mux_pkg::KIND_FUNC;
        d.port = 3'(k);
      end
      if (idx == gpio_pin_mux_pkg::DIR_IDX[k]) begin
        d.kind = gpio_pin_mux_pkg::KIND_DIR;
        d.port = 3'(k);
      end
      if (k < gpio_pin_mux_pkg::NUM_FILT_PORTS) begin
        // The two-bit index keeps the unrolled select inside the four filtered ports.
        if (idx == gpio_pin_mux_pkg::FILT_IDX[k[1:0]]) begin
          d.kind = gpio_pin_mux_pkg::KIND_FILT;
          d.port = 3'(k);
        end
      end
      if (idx == gpio_pin_mux_pkg::VALUE_IDX[k]) begin
        d.kind = gpio_pin_mux_pkg::KIND_VALUE;
        d.port = 3'(k);
      end
      if (idx == gpio_pin_mux_pkg::HIGH_IDX[k]) begin
        d.kind = gpio_pin_mux_pkg::KIND_HIGH;
        d.port = 3'(k);
      end
      if (idx == gpio_pin_mux_pkg::LOW_IDX[k]) begin
        d.kind = gpio_pin_mux_pkg::KIND_LOW;
        d.port = 3'(k);
      end
      if (idx == gpio_pin_mux_pkg::INV_IDX[k]) begin
        d.kind = gpio_pin_mux_pkg::KIND_INV;
        d.port = 3'(k);
      end
    end
    return d;
  endfunction : decode_index

  // Expand the two low byte strobes into a 16-bit write mask.
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // Write a register with byte lanes: only strobed lanes take the new data.
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wdata,
                                             input logic [3:0] strb);
    return (old & ~lane_mask(strb)) | (wdata & lane_mask(strb));
  endfunction : lane_merge

  gpio_pin_mux_pkg::mux_state_t state_reg;
  gpio_pin_mux_pkg::mux_state_t state_next;

  // Combinational views shared by the read path, the peripheral side and the PWM protection.
  gpio_pin_mux_pkg::port_levels_t in_view;
  gpio_pin_mux_pkg::reg_decode_t dec;
  logic addr_ok;
  logic setup_phase;
  logic access_done;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [7:0] period;
  logic tick;
  logic trip_a_low;
  logic trip_b_low;

  // Input as seen by software and peripherals: filtered pins take the qualifier's level, the rest
  // take the pin directly. The pin input always feeds this view, whatever the function bit says.
  always_comb begin
    for (int k = 0; k < gpio_pin_mux_pkg::NUM_PORTS; k++) begin
      if (k < gpio_pin_mux_pkg::NUM_FILT_PORTS) begin
        in_view[k] = (state_reg.qlev[k[1:0]] & gpio_pin_mux_pkg::FILT_PIN_MASK[k[1:0]]) |
                     (pin_level_in[k] & ~gpio_pin_mux_pkg::FILT_PIN_MASK[k[1:0]]);
      end else begin
        in_view[k] = pin_level_in[k];
      end
    end
  end

  // Address decode; misaligned addresses are refused with an error answer.
  assign dec = decode_index(apb_req.paddr[17:2]);
  assign addr_ok = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[31:18] == 14'h0000);
  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && state_reg.resp.pready;
  assign wdata = apb_req.pwdata[15:0];

  // Read data for the addressed register. Write-only and reserved locations read as zero.
  always_comb begin
    rdata = 16'h0000;
    if (addr_ok) begin
      case (dec.kind)
        gpio_pin_mux_pkg::KIND_FUNC: begin
          rdata = state_reg.func[dec.port];
        end
        gpio_pin_mux_pkg::KIND_DIR: begin
          rdata = state_reg.dir[dec.port];
        end
        gpio_pin_mux_pkg::KIND_FILT: begin
          rdata = state_reg.filt[dec.port[1:0]];
        end
        gpio_pin_mux_pkg::KIND_VALUE: begin
          // Output pins return the latch, never the pin; input pins return the input view, qualified where filtered.
          rdata = (state_reg.value[dec.port] & state_reg.dir[dec.port]) |
                  (in_view[dec.port] & ~state_reg.dir[dec.port]);
        end
        default: begin
          rdata = 16'h0000;
        end
      endcase
    end
  end

  // The trip inputs count as low whatever drives them, including this block's own outputs.
  assign trip_a_low = !in_view[gpio_pin_mux_pkg::PORT_D][gpio_pin_mux_pkg::TRIP_A_BIT];
  assign trip_b_low = !in_view[gpio_pin_mux_pkg::PORT_D][gpio_pin_mux_pkg::TRIP_B_BIT];

  // Next state: bus slave, register writes, qualifiers, pin drive and protection.
  always_comb begin
    state_next = state_reg;
    period = 8'h00;
    tick = 1'b0;

    // Bus slave: answer in the first access cycle, with no wait states.
    case (state_reg.bus)
      gpio_pin_mux_pkg::BUS_IDLE: begin
        if (setup_phase) begin
          state_next.bus = gpio_pin_mux_pkg::BUS_ANSWER;
          state_next.resp.pready = 1'b1;
          state_next.resp.pslverr = !addr_ok;
          state_next.resp.prdata = (addr_ok && !apb_req.pwrite) ? {16'h0000, rdata} :
                                   gpio_pin_mux_pkg::RDATA_RESET;
        end
      end
      gpio_pin_mux_pkg::BUS_ANSWER: begin
        if (access_done || !apb_req.psel) begin
          state_next.bus = gpio_pin_mux_pkg::BUS_IDLE;
          state_next.resp.pready = 1'b0;
          state_next.resp.pslverr = 1'b0;
        end
      end
      default: begin
        state_next.bus = gpio_pin_mux_pkg::BUS_IDLE;
        state_next.resp.pready = 1'b0;
        state_next.resp.pslverr = 1'b0;
      end
    endcase

    // Register writes take effect only at the completing access edge.
    if (access_done && apb_req.pwrite && addr_ok) begin
      case (dec.kind)
        gpio_pin_mux_pkg::KIND_FUNC: begin
          if (write_protect_unlock) begin
            state_next.func[dec.port] = lane_merge(state_reg.func[dec.port], wdata,
                                                   apb_req.pstrb);
          end
        end
        gpio_pin_mux_pkg::KIND_DIR: begin
          if (write_protect_unlock) begin
            state_next.dir[dec.port] = lane_merge(state_reg.dir[dec.port], wdata,
                                                  apb_req.pstrb);
          end
        end
        gpio_pin_mux_pkg::KIND_FILT: begin
          if (write_protect_unlock) begin
            state_next.filt[dec.port[1:0]] = lane_merge(state_reg.filt[dec.port[1:0]], wdata,
                                                        apb_req.pstrb);
          end
        end
        gpio_pin_mux_pkg::KIND_VALUE: begin
          // Stored for every pin; it only shows on pins that are outputs.
          state_next.value[dec.port] = lane_merge(state_reg.value[dec.port], wdata,
                                                  apb_req.pstrb);
        end
        gpio_pin_mux_pkg::KIND_HIGH: begin
          state_next.value[dec.port] = state_reg.value[dec.port] |
                                       (wdata & lane_mask(apb_req.pstrb));
        end
        gpio_pin_mux_pkg::KIND_LOW: begin
          state_next.value[dec.port] = state_reg.value[dec.port] &
                                       ~(wdata & lane_mask(apb_req.pstrb));
        end
        gpio_pin_mux_pkg::KIND_INV: begin
          state_next.value[dec.port] = state_reg.value[dec.port] ^
                                       (wdata & lane_mask(apb_req.pstrb));
        end
        default: begin
          state_next.value = state_reg.value;
        end
      endcase
    end

    // Qualifiers: each filtered port divides the system clock by its period (zero samples every
    // clock). Samples enter a six-deep window; the level moves only on six equal samples, which
    // trades up to six periods of delay for immunity to short spikes.
    for (int q = 0; q < gpio_pin_mux_pkg::NUM_FILT_PORTS; q++) begin
      period = state_reg.filt[q][gpio_pin_mux_pkg::FILT_PERIOD_LSB +:
                                 gpio_pin_mux_pkg::FILT_PERIOD_W];
      tick = (period == 8'h00) || (state_reg.div[q] >= 8'(period - 8'h01));
      state_next.div[q] = tick ? 8'h00 : 8'(state_reg.div[q] + 8'h01);
      for (int b = 0; b < gpio_pin_mux_pkg::PORT_WIDTH; b++) begin
        if (tick) begin
          state_next.hist[q][b] = {state_reg.hist[q][b][4:0], pin_level_in[q][b]};
        end
        if (&state_reg.hist[q][b]) begin
          state_next.qlev[q][b] = 1'b1;
        end else if (~|state_reg.hist[q][b]) begin
          state_next.qlev[q][b] = 1'b0;
        end
      end
    end

    // Pin drive: the function bit picks the source of the output buffer only. In digital mode the
    // direction bit enables the buffer; in peripheral mode the peripheral owns the enable.
    for (int k = 0; k < gpio_pin_mux_pkg::NUM_PORTS; k++) begin
      state_next.pins.level[k] = (periph_drive.level[k] & state_reg.func[k]) |
                                 (state_reg.value[k] & ~state_reg.func[k]);
      state_next.pins.oe_n[k] = (periph_drive.oe_n[k] & state_reg.func[k]) |
                                (~state_reg.dir[k] & ~state_reg.func[k]);
      // The peripheral sees the pin as it stands, so a level driven as GPIO reaches it too.
      state_next.periph_in[k] = in_view[k];
    end

    // PWM protection follows the pin levels, so it acts even when the pins are GPIO outputs.
    state_next.pwm_hiz[0] =
      !in_view[gpio_pin_mux_pkg::PORT_D][gpio_pin_mux_pkg::PROTECT_A_BIT] ||
      (trip_a_low && extended_control_trip_en[0]);
    state_next.pwm_hiz[1] =
      !in_view[gpio_pin_mux_pkg::PORT_D][gpio_pin_mux_pkg::PROTECT_B_BIT] ||
      (trip_b_low && extended_control_trip_en[1]);
  end

  // Single state register. Reset leaves every pin an undriven digital input and the qualifier
  // windows at zero, so a filtered pin held high takes six samples to read high after reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg.bus <= gpio_pin_mux_pkg::BUS_IDLE;
      state_reg.resp.prdata <= gpio_pin_mux_pkg::RDATA_RESET;
      state_reg.resp.pready <= 1'b0;
      state_reg.resp.pslverr <= 1'b0;
      state_reg.func <= {gpio_pin_mux_pkg::NUM_PORTS{gpio_pin_mux_pkg::FUNC_RESET}};
      state_reg.dir <= {gpio_pin_mux_pkg::NUM_PORTS{gpio_pin_mux_pkg::DIR_RESET}};
      state_reg.value <= {gpio_pin_mux_pkg::NUM_PORTS{gpio_pin_mux_pkg::VALUE_RESET}};
      state_reg.filt <= {gpio_pin_mux_pkg::NUM_FILT_PORTS{gpio_pin_mux_pkg::FILT_RESET}};
      state_reg.div <= '0;
      state_reg.hist <= '0;
      state_reg.qlev <= '0;
      state_reg.pins.level <= '0;
      state_reg.pins.oe_n <= '1;
      state_reg.periph_in <= '0;
      state_reg.pwm_hiz <= 2'b00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register.
  assign apb_resp = state_reg.resp;
  assign pin_drive = state_reg.pins;
  assign periph_level = state_reg.periph_in;
  assign pwm_force_hiz = state_reg.pwm_hiz;

endmodule : gpio_pin_mux_port

`default_nettype wire

/* File: gpio_pin_mux_port_checker.sv */
// Checker of bus timing, input filtering and PWM protection at the multiplexer ports.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_mux_port_checker (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Bus, pins, peripherals and protection.
  input wire gpio_pin_mux_pkg::apb_req_t apb_req,
  input wire gpio_pin_mux_pkg::apb_resp_t apb_resp,
  input wire logic write_protect_unlock,
  input wire gpio_pin_mux_pkg::port_levels_t pin_level_in,
  input wire gpio_pin_mux_pkg::pin_drive_t pin_drive,
  input wire gpio_pin_mux_pkg::pin_drive_t periph_drive,
  input wire gpio_pin_mux_pkg::port_levels_t periph_level,
  input wire logic [1:0] extended_control_trip_en,
  input wire logic [1:0] pwm_force_hiz
);
  logic [3:0] hi_cnt;
  logic [3:0] lo_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Run lengths of port A pin 0; they saturate so that a long idle cannot wrap to a short run.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi_cnt <= 4'h0;
      lo_cnt <= 4'h0;
    end else begin
      hi_cnt <= !pin_level_in[0][0] ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
      lo_cnt <= pin_level_in[0][0] ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hF};
    end
  end
  ready_after_setup_a:
    assert property (apb_req.psel && !apb_req.penable && !apb_resp.pready |=> apb_resp.pready)
      else $error("no answer in the cycle after setup");
  ready_single_a:
    assert property (apb_resp.pready |=> !apb_resp.pready) else $error("ready held too long");
  bad_addr_err_a:
    assert property (apb_req.psel && !apb_req.penable && apb_req.paddr[1:0] != 2'b00
      |=> apb_resp.pready && apb_resp.pslverr) else $error("misaligned access not flagged");
  upper_half_zero_a:
    assert property (apb_resp.pready |-> apb_resp.prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
  raw_pass_a:
    assert property (!$past(rst) |-> periph_level[5:4] == $past(pin_level_in[5:4])
      && (periph_level[2] & 16'hFF9C) == ($past(pin_level_in[2]) & 16'hFF9C))
      else $error("unfiltered pin not passed straight on");
  qual_rise_a:
    assert property ($rose(periph_level[0][0]) |-> hi_cnt >= 4'h6)
      else $error("filtered level rose before six high samples");
  qual_fall_a:
    assert property ($fell(periph_level[0][0]) |-> lo_cnt >= 4'h6)
      else $error("filtered level fell before six low samples");
  protect_hiz_a:
    assert property (!periph_level[2][0] [*3] |-> pwm_force_hiz[0])
      else $error("low protect input did not force high impedance");
  trip_hiz_a:
    assert property ((!periph_level[2][6] && extended_control_trip_en[1]) [*3]
      |-> pwm_force_hiz[1]) else $error("enabled low trip did not force high impedance");
  hiz_release_a:
    assert property ((periph_level[2][0] && (periph_level[2][1] || !extended_control_trip_en[0]))
      [*3] |-> !pwm_force_hiz[0]) else $error("high impedance forced without cause");
  cover property (apb_resp.pslverr);
  cover property ($rose(periph_level[0][0]));
  cover property ($rose(pwm_force_hiz[1]));
endmodule : gpio_pin_mux_port_checker

bind gpio_pin_mux_port gpio_pin_mux_port_checker gpio_pin_mux_port_checker_i (.mclk(mclk),
  .rst(rst), .apb_req(apb_req), .apb_resp(apb_resp), .write_protect_unlock(write_protect_unlock),
  .pin_level_in(pin_level_in), .pin_drive(pin_drive), .periph_drive(periph_drive),
  .periph_level(periph_level), .extended_control_trip_en(extended_control_trip_en),
  .pwm_force_hiz(pwm_force_hiz));
`default_nettype wire

/* File: gpio_pin_mux_partner.sv */
// Model of the board pins and of the on-chip peripherals that share them.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_mux_partner (
  // Clock.
  input wire logic mclk,
  // Device drive, board drive and peripheral drive requests.
  input wire gpio_pin_mux_pkg::pin_drive_t pin_drive,
  input wire gpio_pin_mux_pkg::pin_drive_t board_drive,
  input wire gpio_pin_mux_pkg::pin_drive_t periph_src,
  // Resolved pin levels and peripheral outputs.
  output gpio_pin_mux_pkg::port_levels_t pin_level_in,
  output gpio_pin_mux_pkg::pin_drive_t periph_drive
);
  gpio_pin_mux_pkg::port_levels_t float_lvl = '0;
  // Pins have no pull, so an undriven pin shows a level that changes every clock.
  always @(posedge mclk) float_lvl <= ~float_lvl;
  // The device buffer wins and feeds back into the input; otherwise the board drives.
  assign pin_level_in = (~pin_drive.oe_n & pin_drive.level)
    | (pin_drive.oe_n & ~board_drive.oe_n & board_drive.level)
    | (pin_drive.oe_n & board_drive.oe_n & float_lvl);
  // Peripheral drive requests pass straight through, whatever the pin's function bit says.
  assign periph_drive = periph_src;
endmodule : gpio_pin_mux_partner
`default_nettype wire

/* File: gpio_pin_mux_port_test.sv */
// Self-checking bench of the multiplexer: registers, drive, filtering and protection.
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_mux_port_test;
  logic mclk;
  logic rst;
  logic write_protect_unlock;
  logic [1:0] extended_control_trip_en;
  logic [1:0] pwm_force_hiz;
  gpio_pin_mux_pkg::apb_req_t apb_req;
  gpio_pin_mux_pkg::apb_resp_t apb_resp;
  gpio_pin_mux_pkg::port_levels_t pin_level_in;
  gpio_pin_mux_pkg::port_levels_t periph_level;
  gpio_pin_mux_pkg::pin_drive_t pin_drive;
  gpio_pin_mux_pkg::pin_drive_t periph_drive;
  gpio_pin_mux_pkg::pin_drive_t board_drive;
  gpio_pin_mux_pkg::pin_drive_t periph_src;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  gpio_pin_mux_port gpio_pin_mux_port_i (.mclk(mclk), .rst(rst), .apb_req(apb_req),
    .apb_resp(apb_resp), .write_protect_unlock(write_protect_unlock),
    .pin_level_in(pin_level_in), .pin_drive(pin_drive), .periph_drive(periph_drive),
    .periph_level(periph_level), .extended_control_trip_en(extended_control_trip_en),
    .pwm_force_hiz(pwm_force_hiz));
  gpio_pin_mux_partner gpio_pin_mux_partner_i (.mclk(mclk), .pin_drive(pin_drive),
    .board_drive(board_drive), .periph_src(periph_src), .pin_level_in(pin_level_in),
    .periph_drive(periph_drive));

  // Free-running system clock at 200 MHz.
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Watchdog; the whole run needs well under two thousand cycles.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [15:0] wd);
    @(posedge mclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {16'h0000, wd},
                 pstrb: 4'hF};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    @(posedge mclk);
    while (apb_resp.pready !== 1'b1) @(posedge mclk);
    rd = apb_resp.prdata;
    err = apb_resp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    xfer(1'b1, {14'h0000, idx, 2'b00}, d);
  endtask : wr

  task automatic rdchk(input logic [15:0] idx, input logic [15:0] exp);
    xfer(1'b0, {14'h0000, idx, 2'b00}, 16'h0000);
    chk(rd, {16'h0000, exp});
  endtask : rdchk

  // Main sequence; the board holds every pin low until a scenario says otherwise.
  initial begin
    rst = 1'b1;
    apb_req = '0;
    write_protect_unlock = 1'b0;
    extended_control_trip_en = 2'b00;
    board_drive = '{level: '0, oe_n: '0};
    periph_src = '{level: '0, oe_n: '1};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({30'h0, pwm_force_hiz}, 32'h3);
    for (int p = 0; p < 6; p++) begin
      rdchk(gpio_pin_mux_pkg::FUNC_IDX[p], 16'h0000);
      rdchk(gpio_pin_mux_pkg::DIR_IDX[p], 16'h0000);
    end
    // Configuration stays untouched while the unlock is low.
    wr(gpio_pin_mux_pkg::FUNC_IDX[0], 16'hFFFF);
    wr(gpio_pin_mux_pkg::FILT_IDX[0], 16'h00FF);
    rdchk(gpio_pin_mux_pkg::FUNC_IDX[0], 16'h0000);
    rdchk(gpio_pin_mux_pkg::FILT_IDX[0], 16'h0000);
    write_protect_unlock <= 1'b1;
    for (int p = 0; p < 6; p++) begin
      wr(gpio_pin_mux_pkg::DIR_IDX[p], 16'hFFFF);
      rdchk(gpio_pin_mux_pkg::DIR_IDX[p], 16'hFFFF);
    end
    // Reserved places neither store nor disturb their neighbours.
    wr(16'h70C3, 16'hFFFF);
    wr(16'h70DC, 16'hFFFF);
    rdchk(gpio_pin_mux_pkg::FILT_IDX[0], 16'h0000);
    rdchk(gpio_pin_mux_pkg::FUNC_IDX[5], 16'h0000);
    xfer(1'b0, 32'h0001_C382, 16'h0000);
    chk({31'h0, err}, 32'h1);
    write_protect_unlock <= 1'b0;
    // Data registers work while locked; each port goes through set, clear and invert.
    for (int p = 0; p < 6; p++) begin
      wr(gpio_pin_mux_pkg::VALUE_IDX[p], 16'h00F0);
      wr(gpio_pin_mux_pkg::HIGH_IDX[p], 16'h000F);
      wr(gpio_pin_mux_pkg::LOW_IDX[p], 16'h0011);
      wr(gpio_pin_mux_pkg::INV_IDX[p], 16'h0F0F);
      rdchk(gpio_pin_mux_pkg::VALUE_IDX[p], 16'h0FE1);
    end
    repeat (3) @(posedge mclk);
    for (int p = 0; p < 6; p++) begin
      chk({16'h0, pin_drive.level[p]}, 32'h0FE1);
      chk({16'h0, pin_drive.oe_n[p]}, 32'h0000);
    end
    chk({16'h0, periph_level[5]}, 32'h0FE1);
    // Ports F and G go to the peripheral, which drives both; F reads back the pin, G the latch.
    write_protect_unlock <= 1'b1;
    periph_src.level[5:4] <= {16'h5A5A, 16'hA5A5};
    periph_src.oe_n[5:4] <= '0;
    wr(gpio_pin_mux_pkg::FUNC_IDX[4], 16'hFFFF);
    wr(gpio_pin_mux_pkg::DIR_IDX[4], 16'h0000);
    wr(gpio_pin_mux_pkg::FUNC_IDX[5], 16'hFFFF);
    repeat (3) @(posedge mclk);
    chk({16'h0, pin_drive.level[4]}, 32'hA5A5);
    chk({16'h0, pin_drive.oe_n[4]}, 32'h0000);
    chk({16'h0, periph_level[5]}, 32'h5A5A);
    rdchk(gpio_pin_mux_pkg::VALUE_IDX[4], 16'hA5A5);
    rdchk(gpio_pin_mux_pkg::VALUE_IDX[5], 16'h0FE1);
    // Port A pin 0 is filtered with a period of eight clocks.
    wr(gpio_pin_mux_pkg::DIR_IDX[0], 16'h0000);
    wr(gpio_pin_mux_pkg::FILT_IDX[0], 16'h0008);
    repeat (120) @(posedge mclk);
    board_drive.level[0] <= 16'h0001;
    repeat (20) @(posedge mclk);
    board_drive.level[0] <= 16'h0000;
    repeat (120) @(posedge mclk);
    chk({31'h0, periph_level[0][0]}, 32'h0);
    board_drive.level[0] <= 16'h0001;
    repeat (120) @(posedge mclk);
    rdchk(gpio_pin_mux_pkg::VALUE_IDX[0], 16'h0001);
    // Port D drives its own protect and trip pins as general outputs, then the board does.
    wr(gpio_pin_mux_pkg::VALUE_IDX[2], 16'h0063);
    repeat (15) @(posedge mclk);
    chk({30'h0, pwm_force_hiz}, 32'h0);
    extended_control_trip_en <= 2'b11;
    wr(gpio_pin_mux_pkg::LOW_IDX[2], 16'h0002);
    repeat (15) @(posedge mclk);
    chk({30'h0, pwm_force_hiz}, 32'h1);
    wr(gpio_pin_mux_pkg::HIGH_IDX[2], 16'h0002);
    wr(gpio_pin_mux_pkg::LOW_IDX[2], 16'h0020);
    repeat (15) @(posedge mclk);
    chk({30'h0, pwm_force_hiz}, 32'h2);
    board_drive.level[2] <= 16'h0023;
    wr(gpio_pin_mux_pkg::DIR_IDX[2], 16'h0000);
    repeat (15) @(posedge mclk);
    chk({30'h0, pwm_force_hiz}, 32'h2);
    final_report();
  end
endmodule : gpio_pin_mux_port_test
`default_nettype wire
